// File: hw/mcc_top.sv
// Shadow RAM, nonvolatile store, signature check and setup decode
//
// How it works
// (RQ1) Offset code selects (code+1)/16 input shift
// (RQ2) Segment field picks temperature conversion split
// (RQ3) Bit 15 and words 11-16 are inert
// (RQ4) Signature LFSR x16+x15+x2+1, seeded all ones
// (RQ5) Power-up recomputes signature, compares word 17
// (RQ6) ID words sit in shadow until programming
// (RQ7) Programming copies shadow into store, words 11-16 as zero
// (RQ8) Command 40h+addr writes 16-bit data word
// (RQ9) Two ID words form 32-bit identifier
// (RQ10) Calibration mode passes raw samples through
// (RQ11) Host keeps one setup during collection
// (RQ12) Host keeps store setup stable afterwards
`include "mcc_regs.svh"

module mcc_top
    import mcc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire mcc_cmd_t    cmd_i,
    output logic             cmd_ready_o,
    input  wire logic [4:0]  rd_addr_i,
    output logic [15:0]      rd_data_o,
    input  wire logic [15:0] raw_sample_i,
    input  wire logic [15:0] corr_sample_i,
    input  wire logic        sample_valid_i,
    output logic [15:0]      sample_o,
    output logic             sample_valid_o,
    output logic             raw_mode_o,
    output mcc_cfg_t         cfg_o,
    output logic [31:0]      customer_id_o,
    output logic             sig_done_o,
    output logic             sig_ok_o,
    output logic             prog_busy_o
);

    localparam logic [4:0] LAST_IDX = 5'(`MCC_WORDS - 1);

    mcc_regs_t   r;
    mcc_regs_t   next_r;

    // Arrays carry no reset: the store must survive it, shadow is reloaded
    logic [15:0] mtp    [0:`MCC_WORDS-1];
    logic [15:0] shadow [0:`MCC_WORDS-1];

    logic        sh_we;
    logic [4:0]  sh_wa;
    logic [15:0] sh_wd;
    logic        mtp_we;
    logic [4:0]  mtp_wa;
    logic [15:0] mtp_wd;

    // One word through the serial signature register, MSB first
    function automatic logic [15:0] sig_step(input logic [15:0] seed,
                                             input logic [15:0] word);
        logic [15:0] s;
        logic        fb;
        s  = seed;
        fb = 1'b0;
        for (int b = 15; b >= 0; b--) begin
            fb = s[15] ^ word[b];
            s  = {s[14:0], 1'b0};
            if (fb) begin
                s = s ^ `MCC_SIG_POLY; // RQ4
            end
        end
        return s;
    endfunction : sig_step

    logic [15:0] setup_word;
    logic [1:0]  tseg;
    logic [4:0]  wr_addr;
    logic        take;
    logic        is_write;
    logic        addr_inert;

    logic [15:0] prog_word;

    // Unassigned words fold in as zero so stale store content cannot sway the signature
    assign prog_word  = ((r.idx >= `MCC_ADDR_FREE_FIRST) && (r.idx <= `MCC_ADDR_FREE_LAST)) ?
                        16'h0000 : shadow[r.idx]; // RQ3
    assign setup_word = shadow[`MCC_ADDR_SETUP];
    assign tseg       = setup_word[`MCC_TSEG_MSB:`MCC_TSEG_LSB];
    assign wr_addr    = cmd_i.op[4:0];
    assign take       = cmd_i.valid && (r.st == ST_IDLE);
    assign is_write   = (cmd_i.op >= `MCC_CMD_WRITE_BASE) &&
                        (cmd_i.op <= `MCC_CMD_WRITE_LAST);
    // Unassigned words and the signature word never take host data
    assign addr_inert = (wr_addr >= `MCC_ADDR_FREE_FIRST); // RQ3

    always_comb begin
        next_r = r;
        sh_we  = 1'b0;
        sh_wa  = r.idx;
        sh_wd  = 16'h0000;
        mtp_we = 1'b0;
        mtp_wa = r.idx;
        mtp_wd = 16'h0000;

        unique case (r.st)
            ST_LOAD: begin
                // Copy store to shadow while folding words into the signature
                sh_we = 1'b1;
                sh_wd = mtp[r.idx];
                if (r.idx == LAST_IDX) begin
                    next_r.sig_done = 1'b1;
                    next_r.sig_ok   = (r.sig == mtp[r.idx]); // RQ5
                    next_r.st       = ST_IDLE;
                    next_r.idx      = 5'h00;
                end else begin
                    next_r.sig = sig_step(r.sig, mtp[r.idx]); // RQ5
                    next_r.idx = r.idx + 5'h01;
                end
            end
            ST_IDLE: begin
                if (take && is_write && !addr_inert) begin
                    sh_we = 1'b1; // RQ8
                    sh_wa = wr_addr; // RQ8
                    sh_wd = cmd_i.data;
                    if (wr_addr == `MCC_ADDR_SETUP) begin
                        sh_wd[`MCC_RSVD_BIT] = 1'b0; // RQ3
                    end
                end else if (take && cmd_i.op == `MCC_CMD_PROGRAM) begin
                    // Store only changes on this explicit request
                    next_r.st  = ST_PROG; // RQ6
                    next_r.idx = 5'h00;
                    next_r.sig = `MCC_SIG_SEED; // RQ4
                end else if (take && cmd_i.op == `MCC_CMD_RAW_ON) begin
                    next_r.raw_mode = 1'b1; // RQ10
                end else if (take && cmd_i.op == `MCC_CMD_RAW_OFF) begin
                    next_r.raw_mode = 1'b0; // RQ10
                end
            end
            ST_PROG: begin
                // Shadow goes out with words 11-16 as zero, last word is the fresh signature
                mtp_we = 1'b1; // RQ7
                if (r.idx == LAST_IDX) begin
                    mtp_wd          = r.sig;
                    sh_we           = 1'b1;
                    sh_wd           = r.sig;
                    next_r.sig_ok   = 1'b1;
                    next_r.sig_done = 1'b1;
                    next_r.st       = ST_IDLE;
                    next_r.idx      = 5'h00;
                end else begin
                    mtp_wd     = prog_word; // RQ7
                    next_r.sig = sig_step(r.sig, prog_word); // RQ4
                    next_r.idx = r.idx + 5'h01;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase

        // Offset in sixteenths of reference; range runs to 16 minus it
        next_r.cfg.offset_code = setup_word[`MCC_OFS_MSB:`MCC_OFS_LSB]; // RQ1
        next_r.cfg.offset_num  = {2'b00, setup_word[`MCC_OFS_MSB:`MCC_OFS_LSB]}
                                 + 5'h01; // RQ1
        next_r.cfg.range_top   = `MCC_OFS_STEPS - next_r.cfg.offset_num; // RQ1

        next_r.cfg.temp_factory = 1'b0;
        unique case (tseg)
            `MCC_TSEG_FACTORY: begin
                // Factory split lives outside this block
                next_r.cfg.temp_factory = 1'b1; // RQ2
                next_r.cfg.temp_msb     = 5'h00;
                next_r.cfg.temp_lsb     = 3'h0;
            end
            `MCC_TSEG_16_0: begin
                next_r.cfg.temp_msb = `MCC_SEG_MSB_16; // RQ2
                next_r.cfg.temp_lsb = `MCC_SEG_LSB_0;
            end
            `MCC_TSEG_10_6: begin
                next_r.cfg.temp_msb = `MCC_SEG_MSB_10; // RQ2
                next_r.cfg.temp_lsb = `MCC_SEG_LSB_6;
            end
            `MCC_TSEG_12_4: begin
                next_r.cfg.temp_msb = `MCC_SEG_MSB_12; // RQ2
                next_r.cfg.temp_lsb = `MCC_SEG_LSB_4;
            end
        endcase

        next_r.cust_id = {shadow[`MCC_ADDR_ID_HIGH], shadow[`MCC_ADDR_ID_LOW]}; // RQ9

        if (rd_addr_i > `MCC_ADDR_SIG) begin
            next_r.rd_data = 16'h0000;
        end else if (rd_addr_i >= `MCC_ADDR_FREE_FIRST &&
                     rd_addr_i <= `MCC_ADDR_FREE_LAST) begin
            next_r.rd_data = 16'h0000; // RQ3
        end else if (rd_addr_i == `MCC_ADDR_SETUP) begin
            next_r.rd_data = {1'b0, setup_word[14:0]}; // RQ3
        end else begin
            next_r.rd_data = shadow[rd_addr_i];
        end

        // Uncorrected data bypasses the correction path in calibration
        next_r.sample       = r.raw_mode ? raw_sample_i : corr_sample_i; // RQ10
        next_r.sample_valid = sample_valid_i;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r              <= '0;
            r.st           <= ST_LOAD;
            r.sig          <= `MCC_SIG_SEED; // RQ4
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sh_we) begin
            shadow[sh_wa] <= sh_wd; // RQ6
        end
    end

    always_ff @(posedge mclk_i) begin
        if (mtp_we) begin
            mtp[mtp_wa] <= mtp_wd; // RQ7
        end
    end

    assign cmd_ready_o    = (r.st == ST_IDLE);
    assign rd_data_o      = r.rd_data;
    assign sample_o       = r.sample;
    assign sample_valid_o = r.sample_valid;
    assign raw_mode_o     = r.raw_mode;
    assign cfg_o          = r.cfg;
    assign customer_id_o  = r.cust_id;
    assign sig_done_o     = r.sig_done;
    assign sig_ok_o       = r.sig_ok;
    assign prog_busy_o    = (r.st == ST_PROG);

endmodule : mcc_top

// File: hw/mcc_regs.svh
// Word addresses, command codes, field positions and seeds of the config memory block
`ifndef MCC_REGS_SVH
`define MCC_REGS_SVH
`define MCC_WORDS            24
`define MCC_ADDR_ID_LOW      5'h00
`define MCC_ADDR_ID_HIGH     5'h01
`define MCC_ADDR_SETUP       5'h10
`define MCC_ADDR_FREE_FIRST  5'h11
`define MCC_ADDR_FREE_LAST   5'h16
`define MCC_ADDR_SIG         5'h17
`define MCC_CMD_WRITE_BASE   8'h40
`define MCC_CMD_WRITE_LAST   8'h57
`define MCC_CMD_PROGRAM      8'hC3
`define MCC_CMD_RAW_ON       8'h70
`define MCC_CMD_RAW_OFF      8'h71
`define MCC_OFS_LSB          10
`define MCC_OFS_MSB          12
`define MCC_TSEG_LSB         13
`define MCC_TSEG_MSB         14
`define MCC_RSVD_BIT         15
`define MCC_OFS_STEPS        5'h10
`define MCC_SIG_SEED         16'hFFFF
`define MCC_SIG_POLY         16'h8005
`define MCC_TSEG_FACTORY     2'h0
`define MCC_TSEG_16_0        2'h1
`define MCC_TSEG_10_6        2'h2
`define MCC_TSEG_12_4        2'h3
`define MCC_SEG_MSB_16       5'h10
`define MCC_SEG_MSB_10       5'h0A
`define MCC_SEG_MSB_12       5'h0C
`define MCC_SEG_LSB_0        3'h0
`define MCC_SEG_LSB_6        3'h6
`define MCC_SEG_LSB_4        3'h4
`endif

// File: hw/mcc_pkg.sv
// Types shared by the config memory block
package mcc_pkg;
    typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_PROG} mcc_state_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  op;
        logic [15:0] data;
    } mcc_cmd_t;

    typedef struct packed {
        logic [2:0] offset_code;
        logic [4:0] offset_num;
        logic [4:0] range_top;
        logic       temp_factory;
        logic [4:0] temp_msb;
        logic [2:0] temp_lsb;
    } mcc_cfg_t;

    typedef struct packed {
        mcc_state_t  st;
        logic [4:0]  idx;
        logic [15:0] sig;
        logic        sig_done;
        logic        sig_ok;
        logic        raw_mode;
        logic [31:0] cust_id;
        mcc_cfg_t    cfg;
        logic [15:0] rd_data;
        logic [15:0] sample;
        logic        sample_valid;
    } mcc_regs_t;
endpackage : mcc_pkg

// File: verif/mcc_top_asserts.sv
// Port checker for the config memory block
module mcc_top_asserts
    import mcc_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire mcc_cmd_t    cmd_i,
    input wire logic        cmd_ready_o,
    input wire logic [4:0]  rd_addr_i,
    input wire logic [15:0] rd_data_o,
    input wire logic [15:0] raw_sample_i,
    input wire logic [15:0] corr_sample_i,
    input wire logic [15:0] sample_o,
    input wire logic        sample_valid_o,
    input wire logic        raw_mode_o,
    input wire mcc_cfg_t    cfg_o,
    input wire logic [31:0] customer_id_o,
    input wire logic        sig_ok_o,
    input wire logic        prog_busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_take(logic [7:0] op);
        cmd_i.valid && cmd_ready_o && cmd_i.op == op;
    endsequence
    // Busy for all 24 copy cycles, port closed meanwhile
    sequence s_prog_run;
        (prog_busy_o && !cmd_ready_o) throughout ##23 1'b1;
    endsequence
    a_prog_start: assert property (s_take(8'hC3) |=> prog_busy_o)
        else $error("program did not start");
    a_prog_len: assert property ($rose(prog_busy_o) |-> s_prog_run ##1 (!prog_busy_o && sig_ok_o))
        else $error("program length or result wrong");
    a_raw_on: assert property (s_take(8'h70) |=> raw_mode_o)
        else $error("raw mode not entered");
    a_sample_sel: assert property (sample_valid_o |-> sample_o == ($past(raw_mode_o) ?
        $past(raw_sample_i) : $past(corr_sample_i)))
        else $error("wrong sample source");
    a_write_id: assert property (s_take(8'h40) |-> ##2 customer_id_o[15:0] == $past(cmd_i.data, 2))
        else $error("id word not stored");
    a_inert_read: assert property ($past(rd_addr_i) inside {[5'h11:5'h16]} |-> rd_data_o == 16'h0)
        else $error("unassigned word not zero");
    a_rsvd_bit: assert property ($past(rd_addr_i) == 5'h10 |-> !rd_data_o[15])
        else $error("reserved bit set");
    a_ofs_decode: assert property (sig_ok_o |-> cfg_o.offset_num == cfg_o.offset_code + 5'h1
        && cfg_o.range_top == 5'h10 - cfg_o.offset_num)
        else $error("offset decode wrong");
    a_tseg_decode: assert property (sig_ok_o && !cfg_o.temp_factory |->
        cfg_o.temp_msb + cfg_o.temp_lsb == 5'h10)
        else $error("segment split wrong");
endmodule : mcc_top_asserts

// File: verif/mcc_host.sv
// Calibration host model driving the command port
module mcc_host
    import mcc_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic cmd_ready_i,
    output mcc_cmd_t  cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cmd_o = '0;
    // Called just after an edge; held until an edge with ready high
    task automatic send(input logic [7:0] op, input logic [15:0] d);
        logic ok;
        cmd_o = '{1'b1, op, d};
        do begin
            ok = cmd_ready_i;
            @(posedge mclk_i);
        end while (ok !== 1'b1);
        #1 cmd_o = '{1'b0, ~op, ~d};
    endtask : send
endmodule : mcc_host

// File: verif/tb_mtp_config_checksum_calib.sv
// Bench for the config memory block with reference model
module tb_mtp_config_checksum_calib;
    import mcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [4:0]  rd_addr_i = '0;
    logic [15:0] raw_sample_i = '0;
    logic [15:0] corr_sample_i = '0;
    logic        sample_valid_i = 1'b0;
    mcc_cmd_t    cmd_i;
    logic        cmd_ready_o, sample_valid_o, raw_mode_o, sig_done_o, sig_ok_o, prog_busy_o;
    logic [15:0] rd_data_o, sample_o;
    logic [31:0] customer_id_o, w;
    mcc_cfg_t    cfg_o, e;
    logic [4:0]  msb [4] = '{5'h00, 5'h10, 5'h0A, 5'h0C};
    logic [2:0]  lsb [4] = '{3'h0, 3'h0, 3'h6, 3'h4};
    int          errors = 0, num_checks = 0, sh [24];
    mcc_top dut_u (.*);
    mcc_host host_u (.mclk_i(mclk_i), .cmd_ready_i(cmd_ready_o), .cmd_o(cmd_i));
    initial forever #10 mclk_i = ~mclk_i;
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask : step
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [31:0] x);
        rd_addr_i = a;
        step();
        chk(rd_data_o, x);
    endtask : rd
    task automatic wait_rdy();
        for (int n = 0; n < 60 && cmd_ready_o !== 1'b1; n++)
            step();
        chk(cmd_ready_o, 1);
    endtask : wait_rdy
    // MSB-first over words 00..16, seed all ones
    function automatic logic [15:0] crc();
        logic [15:0] c;
        c = 16'hFFFF;
        for (int a = 0; a < 23; a++)
            for (int b = 15; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ sh[a][b]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction : crc
    task automatic summarize();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    initial begin
        void'($urandom(32'he865));
        repeat (5) step();
        sys_rst_i = 1'b0;
        wait_rdy();
        for (int a = 0; a < 17; a++) begin
            sh[a] = $urandom_range(16'hFFFF);
            host_u.send(8'(8'h40 + a), 16'(sh[a]));
            if (a == 16)
                sh[a] &= 16'h7FFF;
            rd(5'(a), sh[a]);
        end
        host_u.send(8'h51, 16'hFFFF);
        rd(5'h11, 0);
        host_u.send(8'hC3, 16'h0000);
        wait_rdy();
        chk(sig_ok_o, 1);
        rd(5'h17, crc());
        sys_rst_i = 1'b1;
        repeat (5) step();
        sys_rst_i = 1'b0;
        wait_rdy();
        chk(sig_done_o & sig_ok_o, 1);
        chk(customer_id_o, {sh[1][15:0], sh[0][15:0]});
        rd(5'h17, crc());
        for (int i = 0; i < 8; i++) begin
            w = $urandom() & 32'h81FF | i << 10 | (i % 4) << 13;
            host_u.send(8'h50, w[15:0]);
            step();
            step();
            e = '{3'(i), 5'(i + 1), 5'(15 - i), i % 4 == 0, msb[i % 4], lsb[i % 4]};
            chk(cfg_o, e);
            rd(5'h10, w & 32'h7FFF);
        end
        // Setup word left alone while samples are collected
        host_u.send(8'h70, 16'h0000);
        for (int k = 0; k < 16; k++) begin
            if (k == 8)
                host_u.send(8'h71, 16'h0000);
            raw_sample_i = 16'($urandom());
            corr_sample_i = 16'($urandom());
            sample_valid_i = 1'(k);
            step();
            chk(sample_o, k < 8 ? raw_sample_i : corr_sample_i);
            chk({raw_mode_o, sample_valid_o}, {k < 8, sample_valid_i});
        end
        summarize();
    end
    // Whole run needs well under 1000 cycles
    initial begin
        #100us;
        errors++;
        summarize();
    end
endmodule : tb_mtp_config_checksum_calib
bind mcc_top mcc_top_asserts chk_u (.*);
